// >>> pccs_pkg.sv
// package for the cable clock and status block: rate selections, divider counts, status types
// assumes a 48 MHz reference as the rate source; control logic itself runs on core_clk
package pccs_pkg;

  // selection codes as seen by the host, 1..6
  localparam logic [2:0] SEL_24M       = 3'h1;
  localparam logic [2:0] SEL_12M       = 3'h2;
  localparam logic [2:0] SEL_6M        = 3'h3;
  localparam logic [2:0] SEL_3M        = 3'h4;
  localparam logic [2:0] SEL_1M5       = 3'h5;
  localparam logic [2:0] SEL_750K      = 3'h6;
  localparam logic [2:0] SEL_DEFAULT   = SEL_6M;

  // reference tick rate in kHz and half-period counts of each selection in reference ticks
  localparam int         REF_KHZ       = 48000;
  localparam int         RATE_24M_KHZ  = 24000;
  localparam logic [7:0] HALF_24M      = 8'(REF_KHZ / (2 * RATE_24M_KHZ));
  localparam logic [7:0] HALF_12M      = 8'h02;
  localparam logic [7:0] HALF_6M       = 8'h04;
  localparam logic [7:0] HALF_3M       = 8'h08;
  localparam logic [7:0] HALF_1M5      = 8'h10;
  localparam logic [7:0] HALF_750K     = 8'h20;

  typedef enum logic [1:0] {
    PCCS_LED_OFF,
    PCCS_LED_AMBER,
    PCCS_LED_GREEN
  } pccs_led_t;

  typedef enum logic [1:0] {
    PCCS_MODE_SCAN,
    PCCS_MODE_SERIAL,
    PCCS_MODE_SPI
  } pccs_mode_t;

  // target-facing pin group: value and output enable
  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic mode_o;
    logic mode_oe;
    logic data_o;
    logic data_oe;
  } pccs_pins_t;

  // target presence inputs after synchronisation
  typedef struct packed {
    logic attached;
    logic powered;
    logic vref_ok;
  } pccs_sense_t;

endpackage : pccs_pkg

// >>> pccs_sync3.sv
// three-flop synchroniser bank with agreement filter for pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/10ps
module pccs_sync3 #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // a change is accepted once the second and third stages agree
      always_comb begin
        q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;

endmodule : pccs_sync3

// >>> pccs_top.sv
// target-side clock generator, status indicator and suspend driver release
// assumes ref_tick is a one-cycle 48 MHz-rate enable pulse from the usb controller domain logic
// Notes on behaviour
// - six rate selections 1..6 give 24, 12, 6, 3, 1.5 MHz and 750 kHz.
// - after connection the clock runs at selection 3, 6 MHz, until another is asked for.
// - the indicator is amber when no target, no target power, or reference below 1.5 V.
// - the indicator is green only with target attached, powered and reference at or above 1.5 V.
// - the indicator is dark while suspended or disconnected and stays so until resume or reconnection.
// - while suspended the clock, mode-select and data drivers are released.
// - the link runs full speed on a 1.1 host port and high speed on a 2.0 host port.
// - data and mode-select change on falling target clock edges so targets sample on rising.
`timescale 1ns/10ps
module pccs_top (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 ref_tick,
  input  wire logic                 usb_connected,
  input  wire logic                 usb_suspended,
  input  wire logic                 host_is_usb2,
  input  wire logic                 rate_wr,
  input  wire logic [2:0]           rate_sel,
  input  wire pccs_pkg::pccs_mode_t host_mode,
  input  wire logic                 shift_valid,
  input  wire logic                 shift_mode,
  input  wire logic                 shift_data,
  output logic                      shift_ready,
  input  wire logic                 target_attached_pin,
  input  wire logic                 target_powered_pin,
  input  wire logic                 vref_ok_pin,
  output pccs_pkg::pccs_pins_t      target_pins,
  output pccs_pkg::pccs_led_t       status_led,
  output logic                      link_high_speed,
  output logic [2:0]                active_rate
);

  logic [2:0]           sense_sync;
  pccs_pkg::pccs_sense_t sense;

  pccs_sync3 #(.W(3)) u_sync (
    .clk (core_clk),
    .rst (sys_rst),
    .d   ({target_attached_pin, target_powered_pin, vref_ok_pin}),
    .q   (sense_sync)
  );
  assign sense = pccs_pkg::pccs_sense_t'(sense_sync);

  // rate selection state
  logic [2:0] sel_reg;
  logic [2:0] sel_next;
  logic       conn_d_reg;
  logic       conn_d_next;
  logic       active;
  logic       connect_edge;
  logic       rate_ok;
  logic       target_ok;

  assign active       = usb_connected && !usb_suspended;
  // first cycle of a fresh connection: the rate falls back to the default
  assign connect_edge = usb_connected && !conn_d_reg;
  // codes 0 and 7 are not selections and are dropped
  assign rate_ok      = (rate_sel >= pccs_pkg::SEL_24M) && (rate_sel <= pccs_pkg::SEL_750K);
  assign target_ok    = sense.attached && sense.powered && sense.vref_ok;

  always_comb begin
    sel_next    = sel_reg;
    conn_d_next = usb_connected;
    if (connect_edge) begin
      sel_next = pccs_pkg::SEL_DEFAULT;
    end else if (rate_wr && rate_ok) begin
      sel_next = rate_sel;
    end
  end

  // divider: half period of the selected rate in reference ticks
  function automatic logic [7:0] half_of(input logic [2:0] s);
    logic [7:0] h;
    h = pccs_pkg::HALF_6M;
    case (s)
      pccs_pkg::SEL_24M:  h = pccs_pkg::HALF_24M;
      pccs_pkg::SEL_12M:  h = pccs_pkg::HALF_12M;
      pccs_pkg::SEL_6M:   h = pccs_pkg::HALF_6M;
      pccs_pkg::SEL_3M:   h = pccs_pkg::HALF_3M;
      pccs_pkg::SEL_1M5:  h = pccs_pkg::HALF_1M5;
      pccs_pkg::SEL_750K: h = pccs_pkg::HALF_750K;
      default:            h = pccs_pkg::HALF_6M;
    endcase
    return h;
  endfunction : half_of

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] half_reg;
  logic [7:0] half_next;
  logic       sclk_reg;
  logic       sclk_next;
  logic       mode_reg;
  logic       mode_next;
  logic       data_reg;
  logic       data_next;
  logic       fall;

  always_comb begin
    cnt_next  = cnt_reg;
    half_next = half_reg;
    sclk_next = sclk_reg;
    mode_next = mode_reg;
    data_next = data_reg;
    fall      = 1'b0;
    // idle, or the cycle a connection appears: clock parked low, divider loaded with the rate about to stand
    if (!active || connect_edge) begin
      cnt_next  = 8'h00;
      sclk_next = 1'b0;
      half_next = half_of(sel_next);
    end else if (ref_tick) begin
      if (cnt_reg + 8'h01 >= half_reg) begin
        cnt_next  = 8'h00;
        sclk_next = !sclk_reg;
        if (sclk_reg) begin
          fall = 1'b1;
          // new rate only taken at a falling edge, so no short pulse appears
          half_next = half_of(sel_reg);
        end
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
    if (fall && shift_valid) begin
      mode_next = shift_mode;
      data_next = shift_data;
    end
  end

  // ready is the falling-edge cycle itself, so a held request is taken at once
  assign shift_ready = fall;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_reg    <= pccs_pkg::SEL_DEFAULT;
      conn_d_reg <= 1'b0;
      cnt_reg    <= 8'h00;
      half_reg   <= pccs_pkg::HALF_6M;
      sclk_reg   <= 1'b0;
      mode_reg   <= 1'b0;
      data_reg   <= 1'b0;
    end else begin
      sel_reg    <= sel_next;
      conn_d_reg <= conn_d_next;
      cnt_reg    <= cnt_next;
      half_reg   <= half_next;
      sclk_reg   <= sclk_next;
      mode_reg   <= mode_next;
      data_reg   <= data_next;
    end
  end

  // indicator and driver enables
  pccs_pkg::pccs_led_t led_reg;
  pccs_pkg::pccs_led_t led_next;
  logic                oe_reg;
  logic                oe_next;
  logic                hs_reg;
  logic                hs_next;

  always_comb begin
    oe_next = active;
    hs_next = usb_connected ? host_is_usb2 : 1'b0;
    if (!active) begin
      led_next = pccs_pkg::PCCS_LED_OFF;
    end else if (target_ok) begin
      led_next = pccs_pkg::PCCS_LED_GREEN;
    end else begin
      led_next = pccs_pkg::PCCS_LED_AMBER;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_reg <= pccs_pkg::PCCS_LED_OFF;
      oe_reg  <= 1'b0;
      hs_reg  <= 1'b0;
    end else begin
      led_reg <= led_next;
      oe_reg  <= oe_next;
      hs_reg  <= hs_next;
    end
  end

  // pin group registered as a whole; values forced low while released so nothing leaks through
  pccs_pkg::pccs_pins_t pins_reg;
  pccs_pkg::pccs_pins_t pins_next;

  always_comb begin
    pins_next.clk_o   = sclk_next & oe_next;
    pins_next.clk_oe  = oe_next;
    pins_next.mode_o  = mode_next & oe_next;
    pins_next.mode_oe = oe_next;
    pins_next.data_o  = data_next & oe_next;
    pins_next.data_oe = oe_next;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign target_pins         = pins_reg;
  assign status_led          = led_reg;
  assign link_high_speed     = hs_reg;
  assign active_rate         = sel_reg;

  // host_mode is informational here: any selection is allowed in every mode
  logic unused_mode;
  assign unused_mode = ^host_mode;

endmodule : pccs_top

// >>> pccs_target_model.sv
// target chain stand-in: keeps the mode-select and data bits seen at a rising target clock
// assumes it only listens and drives nothing back into the block
`timescale 1ns/10ps
module pccs_target_model (
  input  wire pccs_pkg::pccs_pins_t pins,
  output logic                      got_mode,
  output logic                      got_data
);
  always @(posedge pins.clk_o) begin
    got_mode <= pins.mode_o;
    got_data <= pins.data_o;
  end
endmodule : pccs_target_model

// >>> pccs_top_chk.sv
// assertions on indicator, driver release, rate selection and shifting
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/10ps
module pccs_top_chk (
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic                 usb_connected,
  input wire logic                 usb_suspended,
  input wire logic                 host_is_usb2,
  input wire logic                 rate_wr,
  input wire logic                 shift_valid,
  input wire logic                 shift_mode,
  input wire logic                 shift_data,
  input wire logic                 shift_ready,
  input wire logic                 link_high_speed,
  input wire logic                 target_attached_pin,
  input wire logic                 target_powered_pin,
  input wire logic                 vref_ok_pin,
  input wire logic [2:0]           rate_sel,
  input wire logic [2:0]           active_rate,
  input wire pccs_pkg::pccs_pins_t target_pins,
  input wire pccs_pkg::pccs_led_t  status_led
);
  logic act, sen;
  assign act = usb_connected && !usb_suspended;
  assign sen = target_attached_pin && target_powered_pin && vref_ok_pin;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_led_dark: assert property (!act |=> status_led == pccs_pkg::PCCS_LED_OFF) else $error("led lit");
  a_pins_released: assert property (!act |=>
    {target_pins.clk_o, target_pins.clk_oe, target_pins.mode_oe, target_pins.data_oe} == 4'h0) else $error("driving");
  a_green_lit: assert property ((act && sen) [*6] |=>
    status_led == pccs_pkg::PCCS_LED_GREEN) else $error("led not green");
  a_amber_lit: assert property ((act && !sen && $stable({target_attached_pin, target_powered_pin, vref_ok_pin})) [*6] |=>
    status_led == pccs_pkg::PCCS_LED_AMBER) else $error("led not amber");
  a_default_rate: assert property ($rose(usb_connected) |=> active_rate == pccs_pkg::SEL_DEFAULT) else $error("rate");
  a_rate_taken: assert property (act && $past(usb_connected) && rate_wr && rate_sel inside {[3'h1:3'h6]} |=>
    active_rate == $past(rate_sel)) else $error("rate not taken");
  a_shift_taken: assert property (shift_ready && shift_valid |=> !target_pins.clk_o &&
    {target_pins.mode_o, target_pins.data_o} == $past({shift_mode, shift_data})) else $error("bit lost");
  a_link_speed: assert property ((usb_connected && $stable(host_is_usb2)) [*3] |->
    link_high_speed == host_is_usb2) else $error("link speed");
endmodule : pccs_top_chk
bind pccs_top pccs_top_chk chk_i (.core_clk, .sys_rst, .usb_connected, .usb_suspended, .host_is_usb2, .rate_wr,
  .shift_valid, .shift_mode, .shift_data, .shift_ready, .link_high_speed, .target_attached_pin,
  .target_powered_pin, .vref_ok_pin, .rate_sel, .active_rate, .target_pins, .status_led);

// >>> prog_cable_clock_status_tb.sv
// bench for the cable clock and status block with a target chain stand-in
// assumes ref_tick held high, so a clock phase lasts its half count in core cycles
`timescale 1ns/10ps
module prog_cable_clock_status_tb;
  logic core_clk = 0, sys_rst = 1, ref_tick = 1, usb_connected = 0, usb_suspended = 0, host_is_usb2 = 0;
  logic rate_wr = 0, shift_valid = 0, shift_mode = 0, shift_data = 0, shift_ready, link_high_speed, got_mode, got_data;
  logic target_attached_pin = 0, target_powered_pin = 0, vref_ok_pin = 0;
  logic [2:0] rate_sel = 3'h0, active_rate, e;
  pccs_pkg::pccs_mode_t host_mode = pccs_pkg::PCCS_MODE_SCAN;
  pccs_pkg::pccs_pins_t target_pins;
  pccs_pkg::pccs_led_t status_led;
  int mismatches = 0, check_count = 0, n;
  always #50 core_clk = ~core_clk;
  pccs_top uut (.core_clk, .sys_rst, .ref_tick, .usb_connected, .usb_suspended, .host_is_usb2, .rate_wr, .rate_sel,
    .host_mode, .shift_valid, .shift_mode, .shift_data, .shift_ready, .target_attached_pin, .target_powered_pin,
    .vref_ok_pin, .target_pins, .status_led, .link_high_speed, .active_rate);
  pccs_target_model far_end (.pins(target_pins), .got_mode, .got_data);
  task automatic results;
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic guard;
    @(posedge core_clk);
    #1;
    n++;
    if (n > 200) begin
      mismatches++;
      results;
    end
  endtask : guard
  task automatic wait_clk(input logic lvl);
    n = 0;
    while (target_pins.clk_o !== lvl) guard;
  endtask : wait_clk
  task automatic wr(input logic [2:0] s);
    rate_wr = 1;
    rate_sel = s;
    guard;
    rate_wr = 0;
    if (s inside {[3'h1:3'h6]}) e = s;
    chk(active_rate, e);
    repeat (2) begin
      wait_clk(1);
      wait_clk(0);
    end
    wait_clk(1);
    chk(8'(n), 8'h01 << (e - 3'h1));
    wait_clk(0);
    chk(8'(n), 8'h01 << (e - 3'h1));
  endtask : wr
  task automatic remode(input pccs_pkg::pccs_mode_t md);
    usb_connected = 0;
    repeat (2) guard;
    chk(status_led, pccs_pkg::PCCS_LED_OFF);
    host_mode = md;
    host_is_usb2 = ~host_is_usb2; // alternate so both link speeds are seen
    usb_connected = 1;
    guard;
    e = 3'h3;
    chk(active_rate, e);
    repeat (2) guard;
    chk(link_high_speed, host_is_usb2);
  endtask : remode
  initial begin
    void'($urandom(84916));
    repeat (6) @(posedge core_clk);
    #1 sys_rst = 0;
    remode(pccs_pkg::PCCS_MODE_SERIAL);
    for (int i = 0; i < 12; i++) wr(i < 8 ? 3'(i) : 3'($urandom));
    for (int i = 0; i < 8; i++) begin
      {target_attached_pin, target_powered_pin, vref_ok_pin} = 3'(i);
      repeat (6) guard;
      chk(status_led, i == 7 ? pccs_pkg::PCCS_LED_GREEN : pccs_pkg::PCCS_LED_AMBER);
    end
    remode(pccs_pkg::PCCS_MODE_SCAN);
    wr(3'($urandom_range(6, 3)));
    repeat (8) begin
      {shift_mode, shift_data} = 2'($urandom);
      shift_valid = 1;
      n = 0;
      while (shift_ready !== 1'b1) guard;
      guard;
      chk({target_pins.mode_o, target_pins.data_o, target_pins.clk_o}, {shift_mode, shift_data, 1'b0});
      shift_valid = 0;
      wait_clk(1);
      chk({got_mode, got_data}, {shift_mode, shift_data});
    end
    usb_suspended = 1;
    repeat (40) guard;
    chk({status_led, target_pins.clk_oe, target_pins.mode_oe, target_pins.data_oe}, 8'h00);
    usb_suspended = 0;
    repeat (6) guard;
    chk(status_led, pccs_pkg::PCCS_LED_GREEN);
    sys_rst = 1;
    guard;
    chk({link_high_speed, target_pins.clk_oe, status_led}, {2'h0, pccs_pkg::PCCS_LED_OFF});
    chk(active_rate, pccs_pkg::SEL_DEFAULT);
    results;
  end
endmodule : prog_cable_clock_status_tb
